// ===== hdl/lcsi_chan.sv
// One channel: enable bits, change detect, clear-on-read flags.
// Assumes synchronised condition levels and one-cycle strobes.
`timescale 1ns/1ps
module lcsi_chan
  import lcsi_pkg::*;
(
  // Clock and reset
  input  wire logic      clk_sys,
  input  wire logic      rst_n,
  // Condition levels, already synchronised
  input  wire lcsi_src_t cond,
  // Register strobes for this channel
  input  wire logic      en_wr,
  input  wire lcsi_src_t en_wdata,
  input  wire logic      st_rd,
  // State seen by the top: register values, change and request
  output      lcsi_src_t en_reg,
  output      lcsi_src_t st_reg,
  output      lcsi_src_t chg,
  output      logic      irq_next
);
  lcsi_src_t prev_reg;  // Condition one cycle ago

  // Previous level for change detection
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg <= EN_RST;
    end else begin
      prev_reg <= cond;
    end
  end

  // Declare and clear both count as a change
  assign chg = cond ^ prev_reg;

  // Enable bits, host written
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      en_reg <= EN_RST;
    end else if (en_wr) begin
      en_reg <= en_wdata;
    end
  end

  // Sticky flags; a change in the read cycle survives the clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= ST_RST;
    end else if (st_rd) begin
      st_reg <= chg;
    end else begin
      st_reg <= st_reg | chg;
    end
  end

  // Request from enabled flags, next-cycle view
  always_comb begin
    irq_next = |(en_reg & st_reg);
  end
endmodule

// ===== hdl/lcsi_pkg.sv
// Constants and types for the per-channel source interrupt logic.
// Assumes an 8-bit register port with a 6-bit byte address.
package lcsi_pkg;
  // Sizes
  localparam int NUM_CH = 3;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int SRC_W  = 4;

  // Bus and source vector types
  typedef logic [ADDR_W-1:0] lcsi_addr_t;
  typedef logic [DATA_W-1:0] lcsi_data_t;
  typedef logic [SRC_W-1:0]  lcsi_src_t;
  typedef lcsi_addr_t        lcsi_ofs_t [NUM_CH];

  // Register offsets, index is the channel
  localparam lcsi_ofs_t EN_OFS = '{6'h01, 6'h09, 6'h11};
  localparam lcsi_ofs_t ST_OFS = '{6'h02, 6'h0A, 6'h12};

  // Source bit positions, shared by enable and status
  localparam int BIT_FIFO   = 3;
  localparam int BIT_UNLOCK = 2;
  localparam int BIT_ABSENT = 1;
  localparam int BIT_DRIVE  = 0;

  // Reset values
  localparam lcsi_src_t  EN_RST   = 4'h0;
  localparam lcsi_src_t  ST_RST   = 4'h0;
  localparam lcsi_data_t RD_IDLE  = 8'h00;
  localparam lcsi_src_t  UPPER_0  = 4'h0;
endpackage

// ===== hdl/lcsi_sync.sv
// Two-stage synchroniser for a vector of detector levels.
// Assumes each bit is a slow level; no bus coherence is needed.
`timescale 1ns/1ps
module lcsi_sync #(
  parameter int WIDTH = 12
) (
  // Clock and reset
  clk_sys,
  rst_n,
  // Levels
  d_async,
  q_sync
);
  input  wire logic             clk_sys;
  input  wire logic             rst_n;
  input  wire logic [WIDTH-1:0] d_async;
  output      logic [WIDTH-1:0] q_sync;

  logic [WIDTH-1:0] meta_reg;  // First stage, read only by second

  // Two flip-flops before any logic looks at the level
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q_sync   <= '0;
    end else begin
      meta_reg <= d_async;
      q_sync   <= meta_reg;
    end
  end
endmodule

// ===== hdl/lcsi_top.sv
// Top of the source-level interrupt logic for three channels.
// Assumes the register port master of the device's host interface
// and detector levels that may come from other clock domains.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module lcsi_top
  import lcsi_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // Register port
  input  wire lcsi_addr_t        reg_addr,
  input  wire lcsi_data_t        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output      lcsi_data_t        reg_rdata_reg,
  // Detector levels, one bit per channel
  input  wire logic [NUM_CH-1:0] fifo_limit_alarm,
  input  wire logic [NUM_CH-1:0] clock_recovery_unlock,
  input  wire logic [NUM_CH-1:0] signal_absent_defect,
  input  wire logic [NUM_CH-1:0] drive_monitor_output,
  // Requests toward block-level aggregation
  output      logic [NUM_CH-1:0] src_irq_reg
);

  // Enable register hit for a channel
  function automatic logic en_hit(input lcsi_addr_t a,
                                  input int ch);
    en_hit = (a == EN_OFS[ch]);
  endfunction

  // Status register hit for a channel
  function automatic logic st_hit(input lcsi_addr_t a,
                                  input int ch);
    st_hit = (a == ST_OFS[ch]);
  endfunction

  // Any mapped register hit, used to judge unmapped reads
  function automatic logic any_hit(input lcsi_addr_t a);
    any_hit = 1'b0;
    for (int c = 0; c < NUM_CH; c++) begin
      // Either register of this channel
      if (en_hit(a, c) || st_hit(a, c)) begin
        any_hit = 1'b1;
      end
    end
  endfunction

  // Packed condition vectors, channel-major
  logic [NUM_CH*SRC_W-1:0] cond_raw;   // From detector pins
  logic [NUM_CH*SRC_W-1:0] cond_sync;  // After two flops

  // Per-channel state from the channel slices
  lcsi_src_t en_q   [NUM_CH];  // Enable bits
  lcsi_src_t st_q   [NUM_CH];  // Sticky flags
  lcsi_src_t chg_q  [NUM_CH];  // Change this cycle
  logic      irq_d  [NUM_CH];  // Request next value
  logic      en_wr  [NUM_CH];  // Enable write strobe
  logic      st_rd  [NUM_CH];  // Status read strobe

  // Read data next value
  lcsi_data_t rd_next;

  // Gather detector pins into source positions
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_pack
      // FIFO limit alarm on bit 3
      assign cond_raw[g*SRC_W+BIT_FIFO]   = fifo_limit_alarm[g];
      // Clock recovery unlock on bit 2
      assign cond_raw[g*SRC_W+BIT_UNLOCK] = clock_recovery_unlock[g];
      // Signal absent defect on bit 1
      assign cond_raw[g*SRC_W+BIT_ABSENT] = signal_absent_defect[g];
      // Drive monitor output on bit 0
      assign cond_raw[g*SRC_W+BIT_DRIVE]  = drive_monitor_output[g];
    end
  endgenerate

  // Detector levels cross into the register clock
  lcsi_sync #(
    .WIDTH (NUM_CH*SRC_W)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d_async (cond_raw),
    .q_sync  (cond_sync)
  );

  // One slice per channel
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_chan
      // Decode strobes for this channel
      assign en_wr[g] = reg_wr && en_hit(reg_addr, g);
      assign st_rd[g] = reg_rd && st_hit(reg_addr, g);

      lcsi_chan u_chan (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .cond     (cond_sync[g*SRC_W +: SRC_W]),
        .en_wr    (en_wr[g]),
        .en_wdata (reg_wdata[SRC_W-1:0]),
        .st_rd    (st_rd[g]),
        .en_reg   (en_q[g]),
        .st_reg   (st_q[g]),
        .chg      (chg_q[g]),
        .irq_next (irq_d[g])
      );
    end
  endgenerate

  // Read mux; unmapped and idle cycles give zero
  always_comb begin
    rd_next = RD_IDLE;
    if (reg_rd) begin
      for (int c = 0; c < NUM_CH; c++) begin
        // Enable register, upper nibble zero
        if (en_hit(reg_addr, c)) begin
          rd_next = {UPPER_0, en_q[c]};
        end
        // Status register, value before the clear
        if (st_hit(reg_addr, c)) begin
          rd_next = {UPPER_0, st_q[c]};
        end
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_reg <= RD_IDLE;
    end else begin
      reg_rdata_reg <= rd_next;
    end
  end

  // Request outputs, registered per channel
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      src_irq_reg <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        src_irq_reg[c] <= irq_d[c];
      end
    end
  end

  // Checks share the register clock and reset
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // Upper read bits never carry data
  upper_zero_a:
    assert property (reg_rdata_reg[DATA_W-1:SRC_W] == UPPER_0)
    else $error("Read data upper nibble not zero");

  // No read strobe, no read data
  rd_idle_a:
    assert property (!reg_rd |=> reg_rdata_reg == RD_IDLE)
    else $error("Read data outside read answer");

  // Unmapped reads answer zero
  rd_unmapped_a:
    assert property (reg_rd && !any_hit(reg_addr) |=> reg_rdata_reg == RD_IDLE)
    else $error("Unmapped read data not zero");

  // Per-channel checks
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_chk
      // Written enable bits read back
      en_write_a:
        assert property (reg_wr && en_hit(reg_addr, g)
                         |=> en_q[g] == $past(reg_wdata[SRC_W-1:0]))
        else $error("Enable write not stored");

      // Enable read returns stored bits
      en_read_a:
        assert property (reg_rd && en_hit(reg_addr, g)
                         |=> reg_rdata_reg == {UPPER_0, $past(en_q[g])})
        else $error("Enable read data wrong");

      // Enables hold without a write
      en_hold_a:
        assert property (!(reg_wr && en_hit(reg_addr, g))
                         |=> $stable(en_q[g]))
        else $error("Enable bits changed without write");

      // Status read returns flags before the clear
      st_read_a:
        assert property (reg_rd && st_hit(reg_addr, g)
                         |=> reg_rdata_reg == {UPPER_0, $past(st_q[g])})
        else $error("Status read data wrong");

      // Read clears all but fresh changes
      st_clear_a:
        assert property (reg_rd && st_hit(reg_addr, g)
                         |=> st_q[g] == $past(chg_q[g]))
        else $error("Status not cleared by read");

      // Flags never drop without a read
      st_sticky_a:
        assert property (!(reg_rd && st_hit(reg_addr, g))
                         |=> (st_q[g] & $past(st_q[g])) == $past(st_q[g]))
        else $error("Flag lost without read");

      // FIFO limit change sets bit 3
      fifo_change_a:
        assert property ($changed(cond_sync[g*SRC_W+BIT_FIFO])
                         |=> st_q[g][BIT_FIFO])
        else $error("FIFO limit change not flagged");

      // Unlock change sets bit 2
      unlock_change_a:
        assert property ($changed(cond_sync[g*SRC_W+BIT_UNLOCK])
                         |=> st_q[g][BIT_UNLOCK])
        else $error("Unlock change not flagged");

      // Signal absent change sets bit 1
      absent_change_a:
        assert property ($changed(cond_sync[g*SRC_W+BIT_ABSENT])
                         |=> st_q[g][BIT_ABSENT])
        else $error("Signal absent change not flagged");

      // Drive monitor change sets bit 0 once synchronised
      drive_change_a:
        assert property ($changed(cond_sync[g*SRC_W+BIT_DRIVE])
                         |=> st_q[g][BIT_DRIVE])
        else $error("Drive monitor change not flagged");

      // A fresh change always lands in the flags, read or not
      chg_land_a:
        assert property (|chg_q[g]
                         |=> (st_q[g] & $past(chg_q[g])) == $past(chg_q[g]))
        else $error("Fresh change lost");

      // Writes to the status place leave the flags alone
      st_nowrite_a:
        assert property (reg_wr && st_hit(reg_addr, g) && !(|chg_q[g])
                         |=> $stable(st_q[g]))
        else $error("Status changed by a write");

      // Clearing read with no fresh change drops the request
      irq_drop_a:
        assert property (reg_rd && st_hit(reg_addr, g) && !(|chg_q[g])
                         |-> ##2 !src_irq_reg[g])
        else $error("Request stays after clearing read");

      // Drive monitor pin edge flagged three edges later
      drive_pin_a:
        assert property ($changed(drive_monitor_output[g])
                         ##1 (reg_rd != 1'b1) [*3]
                         |-> st_q[g][BIT_DRIVE])
        else $error("Drive monitor edge not flagged");

      // Enabled flag raises the request next edge
      irq_set_a:
        assert property (|(en_q[g] & st_q[g]) |=> src_irq_reg[g])
        else $error("Request missing for enabled flag");

      // No enabled flag, no request
      irq_clr_a:
        assert property (!(|(en_q[g] & st_q[g])) |=> !src_irq_reg[g])
        else $error("Request without enabled flag");

      // Disabled flags never request
      irq_mask_a:
        assert property (en_q[g] == EN_RST |=> !src_irq_reg[g])
        else $error("Request while all sources disabled");
    end
  endgenerate

  // Scenario: request raised then cleared by a status read
  irq_cycle_c:
    cover property (src_irq_reg[0] ##1 reg_rd && st_hit(reg_addr, 0)
                    ##2 !src_irq_reg[0]);

  // Scenario: change arrives in the clearing cycle
  set_wins_c:
    cover property (reg_rd && st_hit(reg_addr, 1) && |chg_q[1]);

  // Scenario: flags held on a channel with all sources disabled
  mask_c:
    cover property (|st_q[1] && en_q[1] == EN_RST);

  // Scenario: all three channels requesting together
  all_irq_c:
    cover property (&src_irq_reg);

  // Scenario: enable write followed directly by status read
  wr_rd_c:
    cover property (reg_wr && en_hit(reg_addr, 2)
                    ##1 reg_rd && st_hit(reg_addr, 2));
endmodule

// ===== testbench/lcsi_det_model.sv
// Detector model: drives the per-channel condition levels.
// Assumes the bench sets a packed level vector, channel-major.
`timescale 1ns/1ps
module lcsi_det_model
  import lcsi_pkg::*;
(
  // Clock
  input  wire logic                    clk_sys,
  // Requested levels, status bit layout per channel
  input  wire logic [NUM_CH*SRC_W-1:0] lvl,
  // Detector levels
  output      logic [NUM_CH-1:0]       fifo_limit_alarm,
  output      logic [NUM_CH-1:0]       clock_recovery_unlock,
  output      logic [NUM_CH-1:0]       signal_absent_defect,
  output      logic [NUM_CH-1:0]       drive_monitor_output
);
  // Levels move only on a clock edge, like registered detectors
  always_ff @(posedge clk_sys) begin
    for (int c = 0; c < NUM_CH; c++) begin
      fifo_limit_alarm[c]      <= lvl[c*SRC_W+BIT_FIFO];
      clock_recovery_unlock[c] <= lvl[c*SRC_W+BIT_UNLOCK];
      signal_absent_defect[c]  <= lvl[c*SRC_W+BIT_ABSENT];
      drive_monitor_output[c]  <= lvl[c*SRC_W+BIT_DRIVE];
    end
  end
endmodule

// ===== testbench/testbench.sv
// Self-checking bench for the three-channel source interrupt logic.
// Assumes the detector model above and a one-cycle-late read port.
`timescale 1ns/1ps
module testbench;
  import lcsi_pkg::*;
  logic                    clk_sys;       // Register clock
  logic                    rst_n;         // Async reset
  lcsi_addr_t              reg_addr;      // Register address
  lcsi_data_t              reg_wdata;     // Write data
  logic                    reg_wr;        // Write strobe
  logic                    reg_rd;        // Read strobe
  lcsi_data_t              reg_rdata_reg; // Read data
  logic [NUM_CH-1:0]       fifo_lvl;      // Detector levels
  logic [NUM_CH-1:0]       unlock_lvl;
  logic [NUM_CH-1:0]       absent_lvl;
  logic [NUM_CH-1:0]       drive_lvl;
  logic [NUM_CH-1:0]       src_irq_reg;   // Requests
  logic [NUM_CH*SRC_W-1:0] lvl;           // Levels asked of the model
  int                      errors;
  int                      checked;

  lcsi_top lcsi_top_i (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_reg(reg_rdata_reg), .fifo_limit_alarm(fifo_lvl),
    .clock_recovery_unlock(unlock_lvl), .signal_absent_defect(absent_lvl),
    .drive_monitor_output(drive_lvl), .src_irq_reg(src_irq_reg));

  lcsi_det_model lcsi_det_model_i (.clk_sys(clk_sys), .lvl(lvl),
    .fifo_limit_alarm(fifo_lvl), .clock_recovery_unlock(unlock_lvl),
    .signal_absent_defect(absent_lvl), .drive_monitor_output(drive_lvl));

  // Compare one value, requests are widened to a byte
  task automatic chk8(input lcsi_data_t got, input lcsi_data_t exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // One-cycle write strobe
  task automatic wr(input lcsi_addr_t a, input lcsi_data_t d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask

  // One-cycle read strobe, data judged in the following cycle
  task automatic rd_chk(input lcsi_addr_t a, input lcsi_data_t exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    chk8(reg_rdata_reg, exp);
  endtask

  // Reset values, an unmapped place, read data lasting one cycle
  task automatic test_reset();
    for (int c = 0; c < NUM_CH; c++) begin
      rd_chk(EN_OFS[c], 8'h00);
      rd_chk(ST_OFS[c], 8'h00);
    end
    rd_chk(6'h03, 8'h00);
    cyc(1);
    chk8(reg_rdata_reg, 8'h00);
  endtask

  // Distinct enable patterns catch aliasing; status ignores writes
  task automatic test_enable();
    for (int c = 0; c < NUM_CH; c++) wr(EN_OFS[c], 8'hF0 | (8'h01 << c));
    for (int c = 0; c < NUM_CH; c++) rd_chk(EN_OFS[c], 8'h01 << c);
    wr(ST_OFS[1], 8'hFF);
    rd_chk(ST_OFS[1], 8'h00);
    for (int c = 0; c < NUM_CH; c++) wr(EN_OFS[c], 8'h0F);
  endtask

  // Each source on each channel, rising then falling
  task automatic test_events();
    for (int c = 0; c < NUM_CH; c++) begin
      for (int b = 0; b < SRC_W; b++) begin
        for (int v = 1; v >= 0; v--) begin
          @(posedge clk_sys);
          lvl[c*SRC_W+b] <= v[0];
          cyc(8);
          chk8(lcsi_data_t'(src_irq_reg), 8'h01 << c);
          rd_chk(ST_OFS[c], 8'h01 << b);
          cyc(2);
          chk8(lcsi_data_t'(src_irq_reg), 8'h00);
        end
      end
    end
  endtask

  // Disabled sources flag without request; clearing is per channel
  task automatic test_mask();
    wr(EN_OFS[1], 8'h00);
    @(posedge clk_sys);
    lvl <= 12'h891;
    cyc(8);
    chk8(lcsi_data_t'(src_irq_reg), 8'h05);
    rd_chk(ST_OFS[1], 8'h09);
    rd_chk(ST_OFS[0], 8'h01);
    cyc(2);
    chk8(lcsi_data_t'(src_irq_reg), 8'h04);
    rd_chk(ST_OFS[2], 8'h08);
    rd_chk(ST_OFS[2], 8'h00);
    cyc(2);
    chk8(lcsi_data_t'(src_irq_reg), 8'h00);
  endtask

  task automatic conclude();
    if (errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Free-running 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Main sequence
  initial begin
    rst_n     = 1'b0;
    reg_addr  = '0;
    reg_wdata = '0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    lvl       = '0;
    errors    = 0;
    checked   = 0;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    test_reset();
    test_enable();
    test_events();
    test_mask();
    conclude();
  end

  // Watchdog well beyond the expected run
  initial begin
    #200000;
    errors++;
    conclude();
  end
endmodule
